// file: shared/bch_pkg.sv
`default_nettype none
package bch_pkg;

    // ---------------------------------------------------------------
    // Register word indexes (byte address = index * 4)
    // ---------------------------------------------------------------
    localparam logic [9:0] BCH_IDX_PREF_LIMIT_HI = 10'h02C;
    localparam logic [9:0] BCH_IDX_IO_BASE_HI = 10'h030;
    localparam logic [9:0] BCH_IDX_IO_LIMIT_HI = 10'h032;
    localparam logic [9:0] BCH_IDX_CAP_HEAD = 10'h034;
    localparam logic [9:0] BCH_IDX_OPT_ROM = 10'h038;
    localparam logic [9:0] BCH_IDX_IRQ_LINE = 10'h03C;
    localparam logic [9:0] BCH_IDX_IRQ_PIN = 10'h03D;
    localparam logic [9:0] BCH_IDX_BRIDGE_CTRL = 10'h03E;
    localparam logic [9:0] BCH_IDX_PORT_CFG = 10'h080;
    localparam logic [9:0] BCH_IDX_EVT_STATUS = 10'h081;
    localparam logic [9:0] BCH_IDX_EVT_MASK = 10'h082;

    // ---------------------------------------------------------------
    // Reset values and fixed values
    // ---------------------------------------------------------------
    localparam logic [31:0] BCH_RST_PREF_LIMIT_HI = 32'h0000_0000;
    localparam logic [15:0] BCH_RST_IO_BASE_HI = 16'hFFFF;
    localparam logic [15:0] BCH_RST_IO_LIMIT_HI = 16'h0000;
    localparam logic [7:0] BCH_CAP_HEAD_VAL = 8'h40;
    localparam logic [31:0] BCH_OPT_ROM_VAL = 32'h0000_0000;
    localparam logic [7:0] BCH_RST_IRQ_LINE = 8'h00;
    localparam logic [7:0] BCH_RST_IRQ_PIN = 8'h00;
    localparam logic [3:0] BCH_RST_PORT_CFG = 4'h3;
    localparam logic [3:0] BCH_RST_EVT = 4'h0;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int BCH_BC_POISON = 0;
    localparam int BCH_BC_ERRFWD = 1;
    localparam int BCH_BC_ISA = 2;
    localparam int BCH_BC_VGA = 3;
    localparam int BCH_BC_HOTRST = 6;
    localparam int BCH_CFG_PREF_WIDE = 0;
    localparam int BCH_CFG_IO_WIDE = 1;
    localparam int BCH_CFG_CMD_SERR = 2;
    localparam int BCH_CFG_DEV_ERR = 3;
    localparam int BCH_EV_POISON = 0;
    localparam int BCH_EV_FWD = 1;
    localparam int BCH_EV_BLOCKED = 2;
    localparam int BCH_EV_HOTRST = 3;

    // AXI responses
    localparam logic [1:0] BCH_RESP_OKAY = 2'b00;
    localparam logic [1:0] BCH_RESP_SLVERR = 2'b10;

    // Error message group on either side of the bridge
    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic cor;
    } bch_err_msg_s;

    // Stored bridge control bits
    typedef struct packed {
        logic hot_reset;
        logic vga_route_enable;
        logic error_forward_enable;
        logic poison_response_enable;
    } bch_bctrl_s;

endpackage : bch_pkg
`default_nettype wire

// file: hw/bch_top.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - 32-bit RW upper prefetch limit, reset zero
// - Upper prefetch limit zero, read-only when narrow
// - 16-bit RW upper I/O limit, reset zero
// - Upper I/O registers zero, read-only when narrow
// - Capability pointer fixed at first structure
// - Option ROM base always zero, writes ignored
// - Interrupt line stored only, reset zero
// - Bit0 enables poisoned TLP detection, reporting
// - Bit1 forwards secondary error messages upstream
// - Forwarding also needs command or devctl enable
// - Bit2 ISA option reads zero always
// - Bit3 forwards VGA addresses downstream
// - Bit6 drives hot reset to secondary
// - Prefetch width bit, one means 64-bit
module bch_top
    import bch_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Secondary side events
    input wire bch_err_msg_s sec_err_msg,
    input wire logic sec_poison_tlp,
    // Primary side and routing outputs
    output bch_err_msg_s pri_err_msg,
    output logic poison_report,
    output logic vga_route_active,
    output logic secondary_hot_reset,
    output logic irq
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // Byte-lane merge, used by every writable register except event status
    function automatic logic [31:0] strb_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] lane;
        lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (new_val & lane) | (old_val & ~lane);
    endfunction : strb_merge

    // Decode of a byte address to a mapped word
    function automatic logic is_mapped(input logic [11:0] addr);
        return addr[11:2] inside {BCH_IDX_PREF_LIMIT_HI, BCH_IDX_IO_BASE_HI,
            BCH_IDX_IO_LIMIT_HI, BCH_IDX_CAP_HEAD, BCH_IDX_OPT_ROM, BCH_IDX_IRQ_LINE,
            BCH_IDX_IRQ_PIN, BCH_IDX_BRIDGE_CTRL, BCH_IDX_PORT_CFG, BCH_IDX_EVT_STATUS,
            BCH_IDX_EVT_MASK};
    endfunction : is_mapped

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic aw_held_ff, nxt_aw_held;
    logic w_held_ff, nxt_w_held;
    logic [11:0] aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0] w_strb_ff, nxt_w_strb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;

    logic [31:0] pref_limit_hi_ff, nxt_pref_limit_hi;
    logic [15:0] io_base_hi_ff, nxt_io_base_hi;
    logic [15:0] io_limit_hi_ff, nxt_io_limit_hi;
    logic [7:0] irq_line_ff, nxt_irq_line;
    logic [7:0] irq_pin_ff, nxt_irq_pin;
    bch_bctrl_s bctrl_ff, nxt_bctrl;
    logic [3:0] port_cfg_ff, nxt_port_cfg;
    logic [3:0] evt_status_ff, nxt_evt_status;
    logic [3:0] evt_mask_ff, nxt_evt_mask;

    bch_err_msg_s pri_err_ff, nxt_pri_err;
    logic poison_rep_ff, nxt_poison_rep;
    logic irq_ff, nxt_irq;

    logic wr_fire;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;
    logic prefetch_wide_capable;
    logic io_wide_capable;
    logic fwd_allowed;
    logic [15:0] bctrl_rd;
    logic [3:0] evt_set;

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------

    // Address and data are latched independently, in either order
    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    // Commit only once both halves are in and no response is pending
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx = aw_addr_ff[11:2];

    // Next state of the write handshake
    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && !aw_held_ff)
        begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff)
        begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = is_mapped(aw_addr_ff) ? BCH_RESP_OKAY : BCH_RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
    end

    // Write handshake registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= BCH_RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            aw_addr_ff <= nxt_aw_addr;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    assign prefetch_wide_capable = port_cfg_ff[BCH_CFG_PREF_WIDE];
    assign io_wide_capable = port_cfg_ff[BCH_CFG_IO_WIDE];

    // Next register values; narrow-mode writes are dropped here
    always_comb
    begin
        logic [31:0] m;
        m = 32'h0000_0000;
        nxt_pref_limit_hi = pref_limit_hi_ff;
        nxt_io_base_hi = io_base_hi_ff;
        nxt_io_limit_hi = io_limit_hi_ff;
        nxt_irq_line = irq_line_ff;
        nxt_irq_pin = irq_pin_ff;
        nxt_bctrl = bctrl_ff;
        nxt_port_cfg = port_cfg_ff;
        nxt_evt_mask = evt_mask_ff;
        if (wr_fire)
        begin
            unique case (wr_idx)
                BCH_IDX_PREF_LIMIT_HI:
                begin
                    if (prefetch_wide_capable)
                        nxt_pref_limit_hi = strb_merge(pref_limit_hi_ff, w_data_ff,
                            w_strb_ff);
                end
                BCH_IDX_IO_BASE_HI:
                begin
                    m = strb_merge({16'h0000, io_base_hi_ff}, w_data_ff, w_strb_ff);
                    if (io_wide_capable)
                        nxt_io_base_hi = m[15:0];
                end
                BCH_IDX_IO_LIMIT_HI:
                begin
                    m = strb_merge({16'h0000, io_limit_hi_ff}, w_data_ff, w_strb_ff);
                    if (io_wide_capable)
                        nxt_io_limit_hi = m[15:0];
                end
                BCH_IDX_IRQ_LINE:
                begin
                    m = strb_merge({24'h00_0000, irq_line_ff}, w_data_ff, w_strb_ff);
                    nxt_irq_line = m[7:0];
                end
                BCH_IDX_IRQ_PIN:
                begin
                    // Stored as written; range is software's duty
                    m = strb_merge({24'h00_0000, irq_pin_ff}, w_data_ff, w_strb_ff);
                    nxt_irq_pin = m[7:0];
                end
                BCH_IDX_BRIDGE_CTRL:
                begin
                    m = strb_merge({16'h0000, bctrl_rd}, w_data_ff, w_strb_ff);
                    // Only implemented bits are kept; the rest never store
                    nxt_bctrl.poison_response_enable = m[BCH_BC_POISON];
                    nxt_bctrl.error_forward_enable = m[BCH_BC_ERRFWD];
                    nxt_bctrl.vga_route_enable = m[BCH_BC_VGA];
                    nxt_bctrl.hot_reset = m[BCH_BC_HOTRST];
                end
                BCH_IDX_PORT_CFG:
                begin
                    m = strb_merge({28'h000_0000, port_cfg_ff}, w_data_ff, w_strb_ff);
                    nxt_port_cfg = m[3:0];
                end
                BCH_IDX_EVT_MASK:
                begin
                    m = strb_merge({28'h000_0000, evt_mask_ff}, w_data_ff, w_strb_ff);
                    nxt_evt_mask = m[3:0];
                end
                default: m = 32'h0000_0000; // Read-only, status, unmapped
            endcase
        end
    end

    // Configuration register storage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pref_limit_hi_ff <= BCH_RST_PREF_LIMIT_HI;
            io_base_hi_ff <= BCH_RST_IO_BASE_HI;
            io_limit_hi_ff <= BCH_RST_IO_LIMIT_HI;
            irq_line_ff <= BCH_RST_IRQ_LINE;
            irq_pin_ff <= BCH_RST_IRQ_PIN;
            bctrl_ff <= '0;
            port_cfg_ff <= BCH_RST_PORT_CFG;
            evt_mask_ff <= BCH_RST_EVT;
        end
        else
        begin
            pref_limit_hi_ff <= nxt_pref_limit_hi;
            io_base_hi_ff <= nxt_io_base_hi;
            io_limit_hi_ff <= nxt_io_limit_hi;
            irq_line_ff <= nxt_irq_line;
            irq_pin_ff <= nxt_irq_pin;
            bctrl_ff <= nxt_bctrl;
            port_cfg_ff <= nxt_port_cfg;
            evt_mask_ff <= nxt_evt_mask;
        end
    end

    // Bridge control read image; ISA and reserved bits tie low
    always_comb
    begin
        bctrl_rd = 16'h0000;
        bctrl_rd[BCH_BC_POISON] = bctrl_ff.poison_response_enable;
        bctrl_rd[BCH_BC_ERRFWD] = bctrl_ff.error_forward_enable;
        bctrl_rd[BCH_BC_ISA] = 1'b0;
        bctrl_rd[BCH_BC_VGA] = bctrl_ff.vga_route_enable;
        bctrl_rd[BCH_BC_HOTRST] = bctrl_ff.hot_reset;
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rd_idx = s_axi_araddr[11:2];

    // Read data is captured at accept and held until taken
    always_comb
    begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && !rvalid_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = is_mapped(s_axi_araddr) ? BCH_RESP_OKAY : BCH_RESP_SLVERR;
            unique case (rd_idx)
                BCH_IDX_PREF_LIMIT_HI: nxt_rdata = prefetch_wide_capable ? pref_limit_hi_ff
                    : 32'h0000_0000;
                BCH_IDX_IO_BASE_HI: nxt_rdata = {16'h0000, io_wide_capable ? io_base_hi_ff
                    : 16'h0000};
                BCH_IDX_IO_LIMIT_HI: nxt_rdata = {16'h0000, io_wide_capable ? io_limit_hi_ff
                    : 16'h0000};
                BCH_IDX_CAP_HEAD: nxt_rdata = {24'h00_0000, BCH_CAP_HEAD_VAL};
                BCH_IDX_OPT_ROM: nxt_rdata = BCH_OPT_ROM_VAL;
                BCH_IDX_IRQ_LINE: nxt_rdata = {24'h00_0000, irq_line_ff};
                BCH_IDX_IRQ_PIN: nxt_rdata = {24'h00_0000, irq_pin_ff};
                BCH_IDX_BRIDGE_CTRL: nxt_rdata = {16'h0000, bctrl_rd};
                BCH_IDX_PORT_CFG: nxt_rdata = {28'h000_0000, port_cfg_ff};
                BCH_IDX_EVT_STATUS: nxt_rdata = {28'h000_0000, evt_status_ff};
                BCH_IDX_EVT_MASK: nxt_rdata = {28'h000_0000, evt_mask_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
    end

    // Read channel registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= BCH_RESP_OKAY;
        end
        else
        begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ---------------------------------------------------------------
    // Error forwarding, poison reporting and events
    // ---------------------------------------------------------------
    // Bridge gate and an upstream enable both needed
    assign fwd_allowed = bctrl_ff.error_forward_enable &&
        (port_cfg_ff[BCH_CFG_CMD_SERR] || port_cfg_ff[BCH_CFG_DEV_ERR]);

    // Event sources feeding the sticky status bits
    always_comb
    begin
        evt_set = 4'h0;
        evt_set[BCH_EV_POISON] = sec_poison_tlp && bctrl_ff.poison_response_enable;
        evt_set[BCH_EV_FWD] = (|sec_err_msg) && fwd_allowed;
        evt_set[BCH_EV_BLOCKED] = (|sec_err_msg) && !fwd_allowed;
        evt_set[BCH_EV_HOTRST] = nxt_bctrl.hot_reset && !bctrl_ff.hot_reset;
    end

    // Next outputs and status; a new event beats a same-cycle clear
    always_comb
    begin
        nxt_pri_err = fwd_allowed ? sec_err_msg : '0;
        nxt_poison_rep = sec_poison_tlp && bctrl_ff.poison_response_enable;
        nxt_evt_status = evt_status_ff;
        if (wr_fire && wr_idx == BCH_IDX_EVT_STATUS)
        begin
            nxt_evt_status = evt_status_ff & ~(w_data_ff[3:0] & {4{w_strb_ff[0]}});
        end
        nxt_evt_status = nxt_evt_status | evt_set;
        nxt_irq = |(nxt_evt_status & nxt_evt_mask);
    end

    // Event and output registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pri_err_ff <= '0;
            poison_rep_ff <= 1'b0;
            evt_status_ff <= BCH_RST_EVT;
            irq_ff <= 1'b0;
        end
        else
        begin
            pri_err_ff <= nxt_pri_err;
            poison_rep_ff <= nxt_poison_rep;
            evt_status_ff <= nxt_evt_status;
            irq_ff <= nxt_irq;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign pri_err_msg = pri_err_ff;
    assign poison_report = poison_rep_ff;
    assign vga_route_active = bctrl_ff.vga_route_enable;
    // Level follows the stored bit: held until software clears it
    assign secondary_hot_reset = bctrl_ff.hot_reset;
    assign irq = irq_ff;

endmodule : bch_top
`default_nettype wire

// file: tb/bch_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bch_checker
    import bch_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Events and routing
    input wire bch_err_msg_s sec_err_msg,
    input wire logic sec_poison_tlp,
    input wire bch_err_msg_s pri_err_msg,
    input wire logic poison_report,
    input wire logic vga_route_active,
    input wire logic secondary_hot_reset
);
    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Both halves of a write taken with no answer pending
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence s_wr_answer;
        ##1 s_axi_bvalid;
    endsequence

    property p_wr_answer;
        s_wr_take |=> s_wr_answer;
    endproperty
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    // Only messages seen a cycle earlier may appear upstream
    property p_fwd_cause;
        pri_err_msg != 3'h0 |-> (pri_err_msg & ~$past(sec_err_msg)) == 3'h0;
    endproperty
    property p_poison_cause;
        poison_report |-> $past(sec_poison_tlp);
    endproperty
    // Control levels move only with a committed write
    property p_hot_write;
        $past(aresetn) && $changed(secondary_hot_reset) |-> $rose(s_axi_bvalid);
    endproperty
    property p_vga_write;
        $past(aresetn) && $changed(vga_route_active) |-> $rose(s_axi_bvalid);
    endproperty

    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    a_fwd_cause: assert property (p_fwd_cause) else $error("bad forward");
    a_poison_cause: assert property (p_poison_cause) else $error("bad poison");
    a_hot_write: assert property (p_hot_write) else $error("hot reset moved");
    a_vga_write: assert property (p_vga_write) else $error("vga moved");
endmodule : bch_checker

bind bch_top bch_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sec_err_msg(sec_err_msg), .sec_poison_tlp(sec_poison_tlp), .pri_err_msg(pri_err_msg),
    .poison_report(poison_report), .vga_route_active(vga_route_active),
    .secondary_hot_reset(secondary_hot_reset)
);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import bch_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0, ptlp = 1'h0;
    logic awr, wrd, bv, arr, rv, pp, vga, hot, irq;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rdt;
    logic [3:0] ws = 4'hF;
    logic [1:0] br, rr;
    bch_err_msg_s sem = 3'h0, pem;
    int n_errors = 0, n_tests = 0;
    // Byte addresses: four times the word index
    logic [11:0] wa [11] = '{12'h0B0, 12'h0C0, 12'h0C8, 12'h0F0, 12'h0F4, 12'h208, 12'h0F8,
        12'h0D0, 12'h0E0, 12'h200, 12'h204};
    logic [31:0] wm [9] = '{32'hFFFF_FFFF, 32'hFFFF, 32'hFFFF, 32'hFF, 32'hFF, 32'hF, 32'h4B,
        32'h0, 32'h0};
    logic [31:0] rst_v [11] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h40,
        32'h0, 32'h3, 32'h0};

    bch_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rrd), .sec_err_msg(sem), .sec_poison_tlp(ptlp), .pri_err_msg(pem),
        .poison_report(pp), .vga_route_active(vga), .secondary_hot_reset(hot), .irq(irq)
    );

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    initial
        forever #2 aclk = ~aclk;

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx

    // Interrupt pin kept within zero to four
    function automatic logic [31:0] dat(input int i, input logic [31:0] r);
        return (i == 4) ? r % 5 : r;
    endfunction : dat

    function automatic logic [31:0] rw_exp(input int i, input logic [31:0] r);
        return (dat(i, r) & wm[i]) | ((i == 7) ? 32'h40 : 32'h0);
    endfunction : rw_exp

    task automatic wrap_up;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            n_errors++;
        end
    endtask : chk

    task automatic hang(input int i);
        if (i >= 40)
        begin
            n_errors++;
            wrap_up();
        end
    endtask : hang

    // Ready sampled mid-cycle, as the next rising edge sees it
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int i;
        logic ta, tw, tb;
        logic [1:0] rs;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'h1;
        wv <= 1'h1;
        brd <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(negedge aclk);
            ta = awv && awr;
            tw = wv && wrd;
            tb = bv;
            rs = br;
            @(posedge aclk);
            if (ta)
                awv <= 1'h0;
            if (tw)
                wv <= 1'h0;
            if (tb)
                break;
        end
        brd <= 1'h0;
        hang(i);
        chk(rs, er);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] rs;
        @(posedge aclk);
        ara <= a;
        arv <= 1'h1;
        rrd <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(negedge aclk);
            ta = arv && arr;
            tr = rv;
            d = rdt;
            rs = rr;
            @(posedge aclk);
            if (ta)
                arv <= 1'h0;
            if (tr)
                break;
        end
        rrd <= 1'h0;
        hang(i);
        chk(d, e);
        chk(rs, er);
    endtask : rd

    // One-cycle event pulse, answers checked a cycle later
    task automatic ev(input logic [2:0] m, input logic [2:0] em, input logic ep);
        @(posedge aclk);
        sem <= m;
        ptlp <= 1'h1;
        @(posedge aclk);
        sem <= 3'h0;
        ptlp <= 1'h0;
        @(negedge aclk);
        chk(pem, em);
        chk(pp, ep);
        chk(irq, 1'h1);
    endtask : ev

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial
    begin
        int i, k;
        logic [31:0] r, lf;
        logic f;
        lf = 32'h63;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 11; i++) rd(wa[i], rst_v[i], 2'h0);
        // All ones first: fixed bits must not follow
        for (k = 0; k < 4; k++)
        begin
            lf = nx(lf);
            r = (k == 0) ? 32'hFFFF_FFFF : lf;
            for (i = 0; i < 9; i++) wr(wa[i], dat(i, r), 4'hF, 2'h0);
            for (i = 0; i < 9; i++) rd(wa[i], rw_exp(i, r), 2'h0);
            chk(hot, r[6]);
            chk(vga, r[3]);
        end
        wr(12'h0B0, 32'h0, 4'h1, 2'h0);
        rd(12'h0B0, {r[31:8], 8'h0}, 2'h0);
        // Narrow mode hides and freezes the upper halves
        wr(12'h200, 32'h0, 4'hF, 2'h0);
        for (i = 0; i < 3; i++) wr(wa[i], 32'h1234_5678, 4'hF, 2'h0);
        for (i = 0; i < 3; i++) rd(wa[i], 32'h0, 2'h0);
        wr(12'h200, 32'h3, 4'hF, 2'h0);
        rd(12'h0C8, r & 32'hFFFF, 2'h0);
        wr(12'h004, r, 4'hF, BCH_RESP_SLVERR);
        rd(12'h004, 32'h0, BCH_RESP_SLVERR);
        wr(12'h204, 32'hF, 4'hF, 2'h0);
        wr(12'h208, 32'h7, 4'hF, 2'h0);
        for (k = 0; k < 8; k++)
        begin
            lf = nx(lf);
            f = k[0] && (k[1] || k[2]);
            wr(12'h0F8, {30'h0, k[0], k[0]}, 4'hF, 2'h0);
            wr(12'h200, {28'h0, k[2], k[1], 2'h3}, 4'hF, 2'h0);
            ev(lf[2:0] | 3'h1, f ? lf[2:0] | 3'h1 : 3'h0, k[0]);
            rd(12'h204, {29'h0, !f, f, k[0]}, 2'h0);
            wr(12'h204, 32'hF, 4'hF, 2'h0);
        end
        chk(irq, 1'h0);
        // Hot reset event masked first, then unmasked
        wr(12'h0F8, 32'h48, 4'hF, 2'h0);
        chk(hot, 1'h1);
        chk(irq, 1'h0);
        rd(12'h204, 32'h8, 2'h0);
        wr(12'h208, 32'hF, 4'hF, 2'h0);
        chk(irq, 1'h1);
        wr(12'h0F8, 32'h0, 4'hF, 2'h0);
        chk(hot, 1'h0);
        wr(12'h204, 32'h8, 4'hF, 2'h0);
        chk(irq, 1'h0);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
